// File: design/rfid_reader_irq_status.sv
// Interrupt flags, mask and FIFO fill status of the reader core
// Behaviour
// RULE_01: Mask has one bit per source in fixed order; set bit suppresses that source.
// RULE_02: Mask clears to zero at reset and on Set Default.
// RULE_03: Bit 7 sets when oscillator becomes stable after enable.
// RULE_04: Bit 6 sets when target mode, main enable low and RF field detected.
// RULE_05: Bit 6 sets when collision avoidance abandons a transmission.
// RULE_06: Bit 5 sets in receive when FIFO reaches almost-full level.
// RULE_07: Bit 5 sets in transmit when FIFO falls to almost-empty level.
// RULE_08: Bit 4 sets at end of reception.
// RULE_09: Bit 3 sets at end of transmission.
// RULE_10: Bit 2 sets on any receive coding error, parity or framing.
// RULE_11: Bit 1 sets on receive CRC failure.
// RULE_12: Bit 0 reports bit collision, only in ISO-14443A mode.
// RULE_13: Flags clear to zero at reset and on Set Default.
// RULE_14: Reading flags returns them and clears all; controller reads once.
// RULE_15: FIFO status bits 7..2 give unread byte count, 0 to 32.
// RULE_16: Receive water level is 28 bytes, or 24 with select set.
// RULE_17: Transmit water level is 4 bytes, or 8 with select set.
// RULE_18: Interrupt line high while any unmasked flag is set.
`timescale 1ns/1ps
`default_nettype none

module rfid_reader_irq_status
    import rfid_irq_pkg::*;
(
    input  wire logic                       clk_i,
    input  wire logic                       rst_n_i,
    input  wire logic                       clk_en_i,
    input  wire logic                       set_default_i,
    input  wire logic                       osc_stable_i,
    input  wire logic                       ext_field_i,
    input  wire rfid_irq_pkg::irq_events_s  events_i,
    input  wire rfid_irq_pkg::irq_status_s  status_i,
    input  wire logic                       reg_rd_i,
    input  wire logic                       reg_wr_i,
    input  wire logic [7:0]                 reg_addr_i,
    input  wire logic [7:0]                 reg_wdata_i,
    output logic [7:0]                      reg_rdata_o,
    output logic                            irq_line_o
);
    import rfid_irq_pkg::*;

    // Register decode strobes
    logic       flags_sel;
    logic       fifo_sel;
    logic       mask_sel;
    logic       flags_rd;
    logic       mask_wr;

    // Synchronisers and filtered levels
    logic [2:0] osc_sync_q;
    logic [2:0] field_sync_q;
    logic       osc_ok_q;
    logic       field_ok_q;
    logic       flags_osc_seen_q;

    // Previous level conditions for edge detection
    logic       field_cond_q;
    logic       rx_reached_q;
    logic       tx_reached_q;

    // Flag and mask state
    logic [7:0] flags_q;
    logic [7:0] flags_d;
    logic [7:0] mask_q;
    logic [7:0] set_vec;

    // Combinational helpers
    logic [5:0] rx_level;
    logic [5:0] tx_level;
    logic       field_cond;
    logic       rx_reached;
    logic       tx_reached;
    logic [7:0] fifo_stat;

    // Notes for users of this block:
    // Level sources raise a flag only on a rising edge of their condition.
    // A level that stays true after a read therefore does not re-fire;
    // the controller sees one flag per crossing, not a flag storm.
    // Pulse sources are one clock wide and set their flag directly.
    // A source firing in the same cycle as a flag read survives the clear,
    // so no event can slip between the read data and the clear.
    // Set Default wins over every event and over the read clear.
    // The mask gates only the interrupt line; masked flags still latch
    // and read back, so the controller may poll with the line masked.
    // The interrupt line is registered from the next flags: it changes at the
    // same edge as the flags and never glitches while the flag vector settles.
    // Clock enable low freezes every register, synchronisers included,
    // so a pin change during a frozen spell is seen only after release.
    // A select change while a transfer is active may raise the water flag once.
    // The FIFO count is taken as given; values above 32 are not checked.
    // Reads and writes are one-cycle strobes; back-to-back access is fine.
    // Writes to the flag and FIFO status addresses are ignored.
    // Unmapped reads return zero and leave the read-clear flags alone.
    // Read data holds until the next read is taken.
    // A fall and a new rise of the oscillator level give a second flag.
    // Field events pass the same three-stage filter as the oscillator.
    // Limitation: a field glitch shorter than two clocks is lost.

    // Register address decode
    assign flags_sel = (reg_addr_i == FLAGS_ADDR);
    assign fifo_sel  = (reg_addr_i == FIFO_STAT_ADDR);
    assign mask_sel  = (reg_addr_i == MASK_ADDR);

    // Read and write strobes towards the registers
    assign flags_rd = reg_rd_i && flags_sel;
    assign mask_wr  = reg_wr_i && mask_sel;

    // Analog levels enter through three stages; a change is taken only when stages two and three agree
    // Stage one may go metastable, so nothing but stage two reads it
    always_ff @(posedge clk_i or negedge rst_n_i)
    begin
        if (!rst_n_i)
        begin
            osc_sync_q   <= 3'h0;
            field_sync_q <= 3'h0;
            osc_ok_q     <= 1'b0;
            field_ok_q   <= 1'b0;
        end
        else if (clk_en_i)
        begin
            osc_sync_q   <= {osc_sync_q[1:0], osc_stable_i};
            field_sync_q <= {field_sync_q[1:0], ext_field_i};
            if (osc_sync_q[1] == osc_sync_q[2])
            begin
                osc_ok_q <= osc_sync_q[2];
            end
            if (field_sync_q[1] == field_sync_q[2])
            begin
                field_ok_q <= field_sync_q[2];
            end
        end
    end

    // Water level thresholds from the select bits
    assign rx_level = status_i.rx_level_select ? RX_LEVEL_SEL1 : RX_LEVEL_SEL0; // RULE_16
    assign tx_level = status_i.tx_level_select ? TX_LEVEL_SEL1 : TX_LEVEL_SEL0; // RULE_17

    // Level conditions; only their rising edges raise a flag, so a read does not re-fire at once
    // Field condition needs target mode with the main enable off
    assign field_cond = status_i.target_mode && !status_i.main_enable && field_ok_q; // RULE_04
    assign rx_reached = status_i.rx_active && (status_i.fifo_count >= rx_level); // RULE_06
    assign tx_reached = status_i.tx_active && (status_i.fifo_count <= tx_level); // RULE_07

    // Previous values of the level conditions for edge detection
    // Reset to the idle level so no false edge follows reset
    always_ff @(posedge clk_i or negedge rst_n_i)
    begin
        if (!rst_n_i)
        begin
            field_cond_q <= 1'b0;
            rx_reached_q <= 1'b0;
            tx_reached_q <= 1'b0;
        end
        else if (clk_en_i)
        begin
            field_cond_q <= field_cond;
            rx_reached_q <= rx_reached;
            tx_reached_q <= tx_reached;
        end
    end

    // Set vector, one bit per source
    // Collision only counts in ISO-14443A mode
    always_comb
    begin
        set_vec = 8'h00;
        set_vec[BIT_OSC]    = osc_ok_q && !flags_osc_seen_q; // RULE_03
        set_vec[BIT_FIELD]  = (field_cond && !field_cond_q) // RULE_04
                              || events_i.ca_abort; // RULE_05
        set_vec[BIT_WATER]  = (rx_reached && !rx_reached_q) // RULE_06
                              || (tx_reached && !tx_reached_q); // RULE_07
        set_vec[BIT_RX_END] = events_i.rx_end; // RULE_08
        set_vec[BIT_TX_END] = events_i.tx_end; // RULE_09
        set_vec[BIT_CODING] = events_i.coding_err; // RULE_10
        set_vec[BIT_CRC]    = events_i.crc_err; // RULE_11
        set_vec[BIT_COLL]   = events_i.collision && status_i.iso14443a_mode; // RULE_12
    end

    // Oscillator flag fires once per rise of the stable level
    // Seen bit lags the filtered level by one edge
    always_ff @(posedge clk_i or negedge rst_n_i)
    begin
        if (!rst_n_i)
        begin
            flags_osc_seen_q <= 1'b0;
        end
        else if (clk_en_i)
        begin
            flags_osc_seen_q <= osc_ok_q; // RULE_03
        end
    end

    // Read of the flag register clears it, but an event in the same cycle survives
    // Order matters: clear first, then set, then Set Default on top
    always_comb
    begin
        flags_d = flags_q;
        if (flags_rd)
        begin
            flags_d = FLAGS_RESET; // RULE_14
        end
        flags_d = flags_d | set_vec;
        if (set_default_i)
        begin
            flags_d = FLAGS_RESET; // RULE_13
        end
    end

    // Flag register
    // Held while the clock enable is low, pending flags included
    always_ff @(posedge clk_i or negedge rst_n_i)
    begin
        if (!rst_n_i)
        begin
            flags_q <= FLAGS_RESET; // RULE_13
        end
        else if (clk_en_i)
        begin
            flags_q <= flags_d;
        end
    end

    // Mask register, written by the controller
    // Set Default takes priority over a write in the same cycle
    always_ff @(posedge clk_i or negedge rst_n_i)
    begin
        if (!rst_n_i)
        begin
            mask_q <= MASK_RESET; // RULE_02
        end
        else if (clk_en_i)
        begin
            if (set_default_i)
            begin
                mask_q <= MASK_RESET; // RULE_02
            end
            else if (mask_wr)
            begin
                mask_q <= reg_wdata_i; // RULE_01
            end
        end
    end

    // FIFO status: count in bits 7..2, the rest read as zero here
    // Overflow and receive activity bits live elsewhere
    always_comb
    begin
        fifo_stat = 8'h00;
        fifo_stat[7:FIFO_COUNT_LSB_POS] = status_i.fifo_count; // RULE_15
    end

    // Read data captured on the read strobe; the flag value is the one before clearing
    // Unmapped addresses read as zero
    always_ff @(posedge clk_i or negedge rst_n_i)
    begin
        if (!rst_n_i)
        begin
            reg_rdata_o <= 8'h00;
        end
        else if (clk_en_i && reg_rd_i)
        begin
            if (flags_sel)
            begin
                reg_rdata_o <= flags_q; // RULE_14
            end
            else if (fifo_sel)
            begin
                reg_rdata_o <= fifo_stat; // RULE_15
            end
            else if (mask_sel)
            begin
                reg_rdata_o <= mask_q;
            end
            else
            begin
                reg_rdata_o <= 8'h00;
            end
        end
    end

    // Interrupt line registered from the next flags; rises in the same cycle as the flag, and glitch free
    // Computed from the next flags so it rises at the edge that sets the flag
    always_ff @(posedge clk_i or negedge rst_n_i)
    begin
        if (!rst_n_i)
        begin
            irq_line_o <= 1'b0;
        end
        else if (clk_en_i)
        begin
            irq_line_o <= |(flags_d & ~mask_q); // RULE_18 RULE_01
        end
    end

endmodule

`default_nettype wire

// File: design/rfid_irq_pkg.sv
// Package: register map, flag layout and water levels for the reader interrupt block
package rfid_irq_pkg;

    // Register offsets
    localparam logic [7:0] FLAGS_ADDR = 8'h08;
    localparam logic [7:0] FIFO_STAT_ADDR = 8'h09;
    localparam logic [7:0] MASK_ADDR = 8'h07;

    // Flag and mask bit positions
    localparam int unsigned BIT_OSC = 7;
    localparam int unsigned BIT_FIELD = 6;
    localparam int unsigned BIT_WATER = 5;
    localparam int unsigned BIT_RX_END = 4;
    localparam int unsigned BIT_TX_END = 3;
    localparam int unsigned BIT_CODING = 2;
    localparam int unsigned BIT_CRC = 1;
    localparam int unsigned BIT_COLL = 0;

    // FIFO status count field position
    localparam int unsigned FIFO_COUNT_LSB_POS = 2;

    // Reset values
    localparam logic [7:0] FLAGS_RESET = 8'h00;
    localparam logic [7:0] MASK_RESET = 8'h00;

    // Water levels in bytes
    localparam logic [5:0] RX_LEVEL_SEL0 = 6'h1c;
    localparam logic [5:0] RX_LEVEL_SEL1 = 6'h18;
    localparam logic [5:0] TX_LEVEL_SEL0 = 6'h04;
    localparam logic [5:0] TX_LEVEL_SEL1 = 6'h08;

    // Event inputs from the framing engine, all on clk_i
    typedef struct packed {
        logic rx_end;
        logic tx_end;
        logic coding_err;
        logic crc_err;
        logic collision;
        logic ca_abort;
    } irq_events_s;

    // Mode and status levels from the rest of the core, all on clk_i
    typedef struct packed {
        logic       iso14443a_mode;
        logic       target_mode;
        logic       main_enable;
        logic       rx_active;
        logic       tx_active;
        logic       rx_level_select;
        logic       tx_level_select;
        logic [5:0] fifo_count;
    } irq_status_s;

endpackage

// File: test/rfid_irq_props.sv
// Checker bound to the reader interrupt block
`timescale 1ns/1ps
`default_nettype none
module rfid_irq_props
    import rfid_irq_pkg::*;
(
    input wire logic                      clk_i,
    input wire logic                      rst_n_i,
    input wire logic                      clk_en_i,
    input wire logic                      set_default_i,
    input wire logic                      osc_stable_i,
    input wire logic                      ext_field_i,
    input wire rfid_irq_pkg::irq_events_s events_i,
    input wire rfid_irq_pkg::irq_status_s status_i,
    input wire logic                      reg_rd_i,
    input wire logic                      reg_wr_i,
    input wire logic [7:0]                reg_addr_i,
    input wire logic [7:0]                reg_wdata_i,
    input wire logic [7:0]                reg_rdata_o,
    input wire logic                      irq_line_o
);
    logic       go;
    logic [7:0] mk_q;
    default clocking cb @(posedge clk_i); endclocking
    default disable iff (!rst_n_i);
    // Set Default overrides everything, so keep it out
    assign go = clk_en_i && !set_default_i;
    // Shadow mask, the real one is hidden
    always_ff @(posedge clk_i or negedge rst_n_i)
        if (!rst_n_i)
            mk_q <= 8'h00;
        else if (clk_en_i && set_default_i)
            mk_q <= 8'h00;
        else if (clk_en_i && reg_wr_i && reg_addr_i == MASK_ADDR)
            mk_q <= reg_wdata_i;
    sequence s_quiet_read;
        go && reg_rd_i && reg_addr_i == FLAGS_ADDR && events_i == '0;
    endsequence
    a_rx_end_irq: assert property (go && events_i.rx_end && !mk_q[BIT_RX_END] |=> irq_line_o)
        else $error("no irq after rx end");
    a_tx_end_irq: assert property (go && events_i.tx_end && !mk_q[BIT_TX_END] |=> irq_line_o)
        else $error("no irq after tx end");
    a_coding_irq: assert property (go && events_i.coding_err && !mk_q[BIT_CODING] |=> irq_line_o)
        else $error("no irq after coding error");
    a_crc_irq: assert property (go && events_i.crc_err && !mk_q[BIT_CRC] |=> irq_line_o)
        else $error("no irq after crc error");
    a_abort_irq: assert property (go && events_i.ca_abort && !mk_q[BIT_FIELD] |=> irq_line_o)
        else $error("no irq after abort");
    a_default_clear: assert property (clk_en_i && set_default_i |=> !irq_line_o)
        else $error("irq after set default");
    a_read_clears: assert property (s_quiet_read ##1 events_i == '0 ##1 s_quiet_read |=> reg_rdata_o[4:0] == 5'h00)
        else $error("flags survived read");
    a_fifo_count: assert property (go && reg_rd_i && reg_addr_i == FIFO_STAT_ADDR |=> reg_rdata_o == {$past(status_i.fifo_count), 2'b00})
        else $error("fifo count wrong");
    a_mask_read: assert property (go && reg_rd_i && reg_addr_i == MASK_ADDR |=> reg_rdata_o == $past(mk_q))
        else $error("mask readback wrong");
    a_masked_quiet: assert property (mk_q == 8'hff && $past(mk_q) == 8'hff |-> !irq_line_o)
        else $error("irq while all masked");
endmodule
bind rfid_reader_irq_status rfid_irq_props u_props (.*);
`default_nettype wire

// File: test/mcu_model.sv
// Controller model issuing register accesses
`timescale 1ns/1ps
`default_nettype none
module mcu_model (
    input wire logic  clk_i,
    output var logic  rd_o,
    output var logic  wr_o,
    output var logic [7:0] addr_o,
    output var logic [7:0] wdata_o,
    input wire logic [7:0] rdata_i
);
    // Idle bus from time zero, so no unknown strobe reaches the block
    initial
    begin
        rd_o = 1'b0;
        wr_o = 1'b0;
        addr_o = 8'h00;
        wdata_o = 8'h00;
    end
    // One access held for exactly one taken edge
    task automatic access(input logic w, input logic [7:0] a, input logic [7:0] d, output logic [7:0] q);
        @(posedge clk_i);
        #1;
        rd_o = !w;
        wr_o = w;
        addr_o = a;
        wdata_o = d;
        @(posedge clk_i);
        #1;
        rd_o = 1'b0;
        wr_o = 1'b0;
        q = rdata_i;
    endtask
endmodule
`default_nettype wire

// File: test/rfid_reader_irq_status_bench.sv
// Self-checking bench for the reader interrupt block
`timescale 1ns/1ps
`default_nettype none
module rfid_reader_irq_status_bench;
    import rfid_irq_pkg::*;
    logic        clk_i = 1'b0;
    logic        rst_n_i = 1'b0;
    logic        set_default_i = 1'b0;
    logic        osc_stable_i = 1'b0;
    logic        ext_field_i = 1'b0;
    irq_events_s events_i = '0;
    irq_status_s status_i = '0;
    logic        rd = 1'b0;
    logic        wr = 1'b0;
    logic [7:0]  addr = 8'h00;
    logic [7:0]  wdata = 8'h00;
    logic [7:0]  rdata;
    logic        irq;
    int          failures = 0;
    int          total_checks = 0;
    always #25 clk_i = ~clk_i;
    mcu_model u_mcu (.clk_i(clk_i), .rd_o(rd), .wr_o(wr), .addr_o(addr), .wdata_o(wdata), .rdata_i(rdata));
    rfid_reader_irq_status u_dut (.clk_i(clk_i), .rst_n_i(rst_n_i), .clk_en_i(1'b1), .set_default_i(set_default_i),
        .osc_stable_i(osc_stable_i), .ext_field_i(ext_field_i), .events_i(events_i), .status_i(status_i),
        .reg_rd_i(rd), .reg_wr_i(wr), .reg_addr_i(addr), .reg_wdata_i(wdata), .reg_rdata_o(rdata), .irq_line_o(irq));
    task automatic chk(input logic [7:0] got, input logic [7:0] exp);
        total_checks++;
        if (got !== exp)
        begin
            failures++;
            $display("[ERR] %0t got %h expected %h", $time, got, exp);
        end
    endtask
    task automatic rdc(input logic [7:0] a, input logic [7:0] e);
        logic [7:0] q;
        u_mcu.access(1'b0, a, 8'h00, q);
        chk(q, e);
    endtask
    task automatic pulse(input irq_events_s ev, input logic dflt);
        @(posedge clk_i);
        #1;
        events_i = ev;
        set_default_i = dflt;
        @(posedge clk_i);
        #1;
        events_i = '0;
        set_default_i = 1'b0;
    endtask
    // Every pulse source once, then a collision outside its mode
    task automatic t_events();
        irq_events_s ev [6] = '{6'h20, 6'h10, 6'h08, 6'h04, 6'h02, 6'h01};
        logic [7:0]  fl [6] = '{8'h10, 8'h08, 8'h04, 8'h02, 8'h01, 8'h40};
        status_i.iso14443a_mode = 1'b1;
        for (int i = 0; i < 6; i++)
        begin
            pulse(ev[i], 1'b0);
            chk({7'h00, irq}, 8'h01);
            rdc(FLAGS_ADDR, fl[i]);
            rdc(FLAGS_ADDR, 8'h00);
            chk({7'h00, irq}, 8'h00);
        end
        status_i.iso14443a_mode = 1'b0;
        pulse(6'h02, 1'b0);
        rdc(FLAGS_ADDR, 8'h00);
    endtask
    // Masked flag still latches; Set Default wipes flags and mask
    task automatic t_mask();
        logic [7:0] q;
        rdc(8'h0a, 8'h00);
        u_mcu.access(1'b1, MASK_ADDR, 8'h02, q);
        rdc(MASK_ADDR, 8'h02);
        pulse(6'h04, 1'b0);
        chk({7'h00, irq}, 8'h00);
        rdc(FLAGS_ADDR, 8'h02);
        u_mcu.access(1'b1, MASK_ADDR, 8'hff, q);
        pulse(6'h20, 1'b0);
        pulse(6'h00, 1'b1);
        rdc(FLAGS_ADDR, 8'h00);
        rdc(MASK_ADDR, 8'h00);
    endtask
    // Water levels one step short of and at each threshold
    task automatic t_water();
        logic [5:0] lvl [4] = '{6'h1c, 6'h18, 6'h04, 6'h08};
        for (int i = 0; i < 4; i++)
        begin
            status_i.rx_active = (i < 2);
            status_i.tx_active = (i >= 2);
            status_i.rx_level_select = i[0];
            status_i.tx_level_select = i[0];
            status_i.fifo_count = (i < 2) ? lvl[i] - 6'h01 : lvl[i] + 6'h01;
            rdc(FLAGS_ADDR, 8'h00);
            status_i.fifo_count = lvl[i];
            repeat (2) @(posedge clk_i);
            #1;
            rdc(FLAGS_ADDR, 8'h20);
            rdc(FIFO_STAT_ADDR, {lvl[i], 2'b00});
            status_i = '0;
        end
        status_i.fifo_count = 6'h20;
        rdc(FIFO_STAT_ADDR, 8'h80);
    endtask
    // Synchronised level sources need a few edges
    task automatic t_levels();
        osc_stable_i = 1'b1;
        repeat (6) @(posedge clk_i);
        #1;
        rdc(FLAGS_ADDR, 8'h80);
        status_i.target_mode = 1'b1;
        ext_field_i = 1'b1;
        repeat (6) @(posedge clk_i);
        #1;
        rdc(FLAGS_ADDR, 8'h40);
    endtask
    task automatic test_done();
        $display("checks %0d failures %0d", total_checks, failures);
        if (failures == 0 && total_checks > 0)
            $display("Run complete: PASS");
        else
            $display("Run complete: FAIL");
        $finish;
    endtask
    initial
    begin
        repeat (6) @(posedge clk_i);
        #1;
        rst_n_i = 1'b1;
        rdc(FLAGS_ADDR, 8'h00);
        rdc(MASK_ADDR, 8'h00);
        t_events();
        t_mask();
        t_water();
        t_levels();
        test_done();
    end
    // Watchdog well beyond the roughly 120 cycles needed
    initial
    begin
        repeat (3000) @(posedge clk_i);
        failures++;
        test_done();
    end
endmodule
`default_nettype wire
